// ### ctrl_model.sv
// Behavioural controller-in-charge driving the bus side of the event block
module ctrl_model
  import gpib_evt_pkg::*;
(
  input  wire logic   clk_sys_i,
  output iface_state_t st_o,
  output logic [7:0]  dio_o,
  output logic        eoi_o,
  output logic        acc_o,
  output logic [5:0]  lv_o,
  output logic [6:0]  pu_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    st_o = '0;
    dio_o = 8'h00;
    eoi_o = 1'b0;
    acc_o = 1'b0;
    lv_o = 6'h00;
    pu_o = 7'h00;
  end

  task automatic set_st(input iface_state_t s);
    @(posedge clk_sys_i);
    st_o <= s;
  endtask

  task automatic set_lv(input logic [5:0] v);
    @(posedge clk_sys_i);
    lv_o <= v;
  endtask

  task automatic drive(input logic [7:0] d);
    @(posedge clk_sys_i);
    dio_o <= d;
  endtask

  task automatic pulse(input logic [6:0] p);
    @(posedge clk_sys_i);
    pu_o <= p;
    @(posedge clk_sys_i);
    pu_o <= 7'h00;
  endtask

  // Lines go inverted once released so a stale byte never looks valid
  task automatic take(input logic [7:0] d, input logic e);
    @(posedge clk_sys_i);
    dio_o <= d;
    eoi_o <= e;
    acc_o <= 1'b1;
    @(posedge clk_sys_i);
    dio_o <= ~d;
    eoi_o <= 1'b0;
    acc_o <= 1'b0;
  endtask

  // Status byte is read only inside the poll state
  task automatic poll();
    @(posedge clk_sys_i);
    st_o.spas <= 1'b1;
    pulse(7'h01);
    @(posedge clk_sys_i);
    st_o.spas <= 1'b0;
  endtask
endmodule

// ### gpib_evt_defs.svh
// Register codes, field positions, auxiliary codes and reset values
`ifndef GPIB_EVT_DEFS_SVH
`define GPIB_EVT_DEFS_SVH

// Register select codes on the three select pins
`define RS_DATA         3'h0
`define RS_STAT1        3'h1
`define RS_STAT2        3'h2
`define RS_POLL         3'h3
`define RS_ADDR         3'h4
`define RS_PASS         3'h5
`define RS_TERM         3'h7

// First status and mask register bit positions
`define S1_BYTE_IN      0
`define S1_BYTE_OUT     1
`define S1_BUS_ERR      2
`define S1_CLEAR        3
`define S1_END          4
`define S1_TRIGGER      5
`define S1_SEC_CHECK    6
`define S1_UNDEF_CMD    7

// Second status register bit positions
`define S2_ADDR_CHG     0
`define S2_REM_CHG      1
`define S2_LOCK_CHG     2
`define S2_POLL_DONE    3
`define S2_LOCKOUT      4
`define S2_REMOTE       5
`define S2_POLL_ACT     6
`define S2_INT          7

// Second mask register transfer enables
`define M2_IN_XFER      4
`define M2_OUT_XFER     5

// Service request bit of the poll byte
`define POLL_RSV        6

// Auxiliary mode register codes
`define AUX_SEC_REJECT  8'h07
`define AUX_SEC_ACCEPT  8'h0f
`define AUX_PFX_A       3'h4
`define AUX_PFX_B       3'h5
`define AUXA_END_TERM   2
`define AUXB_PASS       0

// Reset values
`define RST_BYTE        8'h00
`define RST_MODE        2'h1

`endif

// ### gpib_evt_monitor.sv
// Port checker for the talker/listener event block
`include "gpib_evt_defs.svh"
module gpib_evt_monitor
  import gpib_evt_pkg::*;
(
  input wire logic         clk_sys_i,
  input wire logic         rst_i,
  input wire host_bus_t    host_i,
  input wire logic [7:0]   d_i,
  input wire logic [7:0]   d_o,
  input wire iface_state_t st_i,
  input wire logic [7:0]   dio_i,
  input wire logic         byte_accept_i,
  input wire logic         out_ready_i,
  input wire logic         trigger_cmd_i,
  input wire logic         poll_read_i,
  input wire logic         int_o,
  input wire logic         transfer_request_pin_o,
  input wire logic         device_fire_pin_o,
  input wire logic         srq_o,
  input wire logic [7:0]   poll_byte_o,
  input wire logic         ah_holdoff_o,
  input wire logic         sec_accept_o,
  input wire logic         sec_reject_o
);
  logic busy_r, busy_nxt, seen_r, seen_nxt, rd_go, wr_go;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Access start is the first cycle of a strobe, as the block takes it
  always_comb begin
    rd_go    = !host_i.cs_n && !host_i.rd_n && !busy_r;
    wr_go    = !host_i.cs_n && !host_i.wr_n && host_i.rd_n && !busy_r;
    busy_nxt = !host_i.cs_n && (!host_i.rd_n || !host_i.wr_n);
    seen_nxt = st_i.spas && (seen_r || (poll_read_i && srq_o));
  end

  always_ff @(posedge clk_sys_i) begin
    busy_r <= rst_i ? 1'b0 : busy_nxt;
    seen_r <= rst_i ? 1'b0 : seen_nxt;
  end

  chk_fire_pulse: assert property (trigger_cmd_i && st_i.lads |=>
    device_fire_pin_o ##1 !device_fire_pin_o) else $error("fire pin pulse missing");
  chk_fire_cause: assert property (device_fire_pin_o |->
    $past(trigger_cmd_i && st_i.lads)) else $error("fire pin without trigger");
  chk_srq_tied: assert property (srq_o == poll_byte_o[6])
    else $error("request line differs from poll byte");
  chk_rsv_clear: assert property ($fell(st_i.spas) && seen_r |=>
    !srq_o && !poll_byte_o[6]) else $error("request kept after poll");
  chk_int_copy: assert property (rd_go && host_i.rs == `RS_ADDR |=>
    d_o[7] == $past(int_o)) else $error("interrupt copy wrong");
  chk_pass_live: assert property (rd_go && host_i.rs == `RS_PASS |=>
    d_o == $past(dio_i) && !ah_holdoff_o) else $error("pass-through read wrong");
  chk_req_clear: assert property ((rd_go || wr_go) && host_i.rs == `RS_DATA &&
    !byte_accept_i && !$rose(out_ready_i) |=> !transfer_request_pin_o)
    else $error("request pin kept after data access");
  chk_sec_reject: assert property (wr_go && host_i.rs == `RS_PASS &&
    d_i == `AUX_SEC_REJECT |=> sec_reject_o ##1 !sec_reject_o) else $error("no reject pulse");
  chk_sec_accept: assert property (wr_go && host_i.rs == `RS_PASS &&
    d_i == `AUX_SEC_ACCEPT |=> sec_accept_o ##1 !sec_accept_o) else $error("no accept pulse");

  cover property ($fell(st_i.spas) && seen_r);
  cover property (device_fire_pin_o);
  cover property (rd_go && host_i.rs == `RS_PASS && ah_holdoff_o);
endmodule

bind gpib_talker_listener_events gpib_evt_monitor gpib_evt_monitor_inst (
  .clk_sys_i, .rst_i, .host_i, .d_i, .d_o, .st_i, .dio_i, .byte_accept_i, .out_ready_i,
  .trigger_cmd_i, .poll_read_i, .int_o, .transfer_request_pin_o, .device_fire_pin_o,
  .srq_o, .poll_byte_o, .ah_holdoff_o, .sec_accept_o, .sec_reject_o
);

// ### gpib_evt_pkg.sv
// Types shared by the talker/listener event logic
package gpib_evt_pkg;

  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_ONE  = 2'h1,
    MODE_TWO  = 2'h2,
    MODE_THREE = 2'h3
  } addr_mode_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] rs;
  } host_bus_t;

  typedef struct packed {
    logic lids;
    logic tids;
    logic major_minor_select;
    logic locs;
    logic rems;
    logic lwls;
    logic rwls;
    logic spas;
    logic lacs;
    logic tacs;
    logic lads;
    logic tads;
    logic tpas;
    logic lpas;
  } iface_state_t;

endpackage

// ### gpib_talker_listener_events.sv
// Event flags, interrupt, transfer request, serial poll and pass-through logic
//
// Contract
// - With only byte-in and out-transfer enabled, pins reflect just those bytes.
// - Set bus error when talking with nba, TACS, DAC and RFD all true.
// - Set clear flag on entering device clear; interface functions untouched.
// - As listener set end flag on EOI, or terminator match when enabled.
// - Trigger message while listen addressed sets flag and pulses fire pin.
// - Secondary check flag only in mode 3; mode 2 automatic, mode 1 ignores.
// - With pass-through enabled flag undefined commands and following secondaries.
// - Addressed commands are ignored while not addressed.
// - Pass-through register reads live data lines; handshake held until read.
// - Low three bits of second status flag address, remote, lockout changes.
// - Bits 4 to 6 of second status are readable state, never interrupts.
// - Poll-done set once on leaving SPAS after a polled service request.
// - Bit 7 of second status equals interrupt pin, copied in address status.
// - Second mask bits 4 and 5 enable request pin on byte in and out.
// - Request pin cleared by data register access, not by status read.
// - Events during a blocked enabled bit are held, moved in if read zero.
// - Poll byte goes out when polled; its bit 6 asserts service request.
// - After the controller reads the byte, request clears and poll-done raises.
// - Polled without request returns last byte, bit 6 clear, no request line.
// - Poll readback shows the byte; bit 6 follows the request line.
// - Mode 3 unknown secondary flags check, sits in pass-through; host rejects.
// - Flags set directly while no enabled flag is up or on that status register's read, else held; masks gate the interrupt and request pins.
`include "gpib_evt_defs.svh"
module gpib_talker_listener_events
  import gpib_evt_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire host_bus_t    host_i,
  input  wire logic [7:0]   d_i,
  output logic      [7:0]   d_o,
  output logic              d_oe_o,
  input  wire iface_state_t st_i,
  input  wire logic [7:0]   dio_i,
  input  wire logic         eoi_i,
  input  wire logic         atn_i,
  input  wire logic         byte_accept_i,
  input  wire logic         out_ready_i,
  input  wire logic         nba_i,
  input  wire logic         dac_i,
  input  wire logic         rfd_i,
  input  wire logic         dcas_i,
  input  wire logic         trigger_cmd_i,
  input  wire logic         addressed_cmd_i,
  input  wire logic         undef_cmd_i,
  input  wire logic         primary_cmd_i,
  input  wire logic         sec_cmd_i,
  input  wire logic         sec_match_i,
  input  wire logic         poll_read_i,
  output logic              int_o,
  output logic              transfer_request_pin_o,
  output logic              device_fire_pin_o,
  output logic              srq_o,
  output logic      [7:0]   poll_byte_o,
  output logic              ah_holdoff_o,
  output logic              sec_accept_o,
  output logic              sec_reject_o,
  output logic      [7:0]   data_out_o,
  output logic              data_out_load_o
);

  // Host access edges
  logic       rd_prev_r;
  logic       wr_prev_r;
  logic       rd_act;
  logic       wr_act;
  logic       rd_start;
  logic       wr_start;
  logic [2:0] sel;

  assign rd_act   = !host_i.cs_n && !host_i.rd_n;
  assign wr_act   = !host_i.cs_n && !host_i.wr_n && host_i.rd_n;
  assign rd_start = rd_act && !rd_prev_r;
  assign wr_start = wr_act && !wr_prev_r;
  assign sel      = host_i.rs;
  assign d_oe_o   = rd_act;

  // Configuration and data registers
  logic [7:0] mask1_r;
  logic [7:0] mask1_nxt;
  logic [7:0] mask2_r;
  logic [7:0] mask2_nxt;
  logic [7:0] poll_r;
  logic [7:0] poll_nxt;
  addr_mode_t mode_r;
  addr_mode_t mode_nxt;
  logic [4:0] aux_a_r;
  logic [4:0] aux_a_nxt;
  logic [4:0] aux_b_r;
  logic [4:0] aux_b_nxt;
  logic [7:0] term_r;
  logic [7:0] term_nxt;
  logic [7:0] din_r;
  logic [7:0] din_nxt;
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic       dout_load_r;
  logic       dout_load_nxt;

  // Event tracking state
  logic       out_prev_r;
  logic       err_prev_r;
  logic       dcas_prev_r;
  logic       spas_prev_r;
  logic       after_undef_r;
  logic       after_undef_nxt;
  logic       poll_seen_r;
  logic       poll_seen_nxt;
  logic       in_live_r;
  logic       in_live_nxt;
  logic       out_live_r;
  logic       out_live_nxt;
  logic       hold_r;
  logic       hold_nxt;
  logic       fire_r;
  logic       accept_r;
  logic       reject_r;
  logic [6:0] chg_prev_r;
  logic [7:0] dout_q_r;
  logic [7:0] d_nxt;

  logic [7:0] ev1;
  logic [3:0] ev2;
  logic [7:0] clr1;
  logic [7:0] stat1;
  logic [3:0] stat2_low;
  logic [7:0] stat2;
  logic       err_cond;
  logic       cmd_ok;
  logic       term_hit;
  logic       poll_exit;
  logic [6:0] chg_now;

  assign err_cond  = nba_i && st_i.tacs && dac_i && rfd_i;
  assign cmd_ok    = !addressed_cmd_i || st_i.lads || st_i.tads;
  assign term_hit  = aux_a_r[`AUXA_END_TERM] && (dio_i == term_r);
  assign poll_exit = spas_prev_r && !st_i.spas;
  assign chg_now   = {st_i.lids, st_i.tids, st_i.major_minor_select,
                      st_i.locs, st_i.rems, st_i.lwls, st_i.rwls};

  always_comb begin
    ev1 = '0;
    ev1[`S1_BYTE_IN]   = byte_accept_i && st_i.lacs;
    ev1[`S1_BYTE_OUT]  = out_ready_i && !out_prev_r;
    ev1[`S1_BUS_ERR]   = err_cond && !err_prev_r;
    ev1[`S1_CLEAR]     = dcas_i && !dcas_prev_r;
    ev1[`S1_END]       = byte_accept_i && st_i.lacs && (eoi_i || term_hit);
    ev1[`S1_TRIGGER]   = trigger_cmd_i && st_i.lads;
    // Mode 2 matches secondaries upstream, mode 1 never sees them
    ev1[`S1_SEC_CHECK] = (mode_r == MODE_THREE) && (st_i.tpas || st_i.lpas)
                         && sec_cmd_i && !sec_match_i;
    ev1[`S1_UNDEF_CMD] = aux_b_r[`AUXB_PASS] && cmd_ok
                         && (undef_cmd_i || (sec_cmd_i && after_undef_r));
  end

  always_comb begin
    ev2 = '0;
    ev2[`S2_ADDR_CHG]  = chg_now[6:4] != chg_prev_r[6:4];
    ev2[`S2_REM_CHG]   = chg_now[3:2] != chg_prev_r[3:2];
    ev2[`S2_LOCK_CHG]  = chg_now[1:0] != chg_prev_r[1:0];
    ev2[`S2_POLL_DONE] = poll_exit && poll_seen_r;
  end

  always_comb begin
    clr1 = '0;
    clr1[`S1_BYTE_IN]  = rd_start && (sel == `RS_DATA);
    clr1[`S1_BYTE_OUT] = (wr_start && (sel == `RS_DATA)) || atn_i || !st_i.tacs;
  end

  status_hold #(.W(8)) u_stat1 (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ev_i      (ev1),
    .mask_i    (mask1_r),
    .rd_i      (rd_start && (sel == `RS_STAT1)),
    .clr_i     (clr1),
    .stat_o    (stat1)
  );

  status_hold #(.W(4)) u_stat2 (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ev_i      (ev2),
    .mask_i    (mask2_r[3:0]),
    .rd_i      (rd_start && (sel == `RS_STAT2)),
    .clr_i     (4'h0),
    .stat_o    (stat2_low)
  );

  // Masks gate the pin and block status updates; second status bits above 3 never reach it
  assign int_o = |(stat1 & mask1_r) || |(stat2_low & mask2_r[3:0]);
  assign stat2 = {int_o, st_i.spas, st_i.rems, st_i.rwls, stat2_low};

  // Request pin survives status reads; data register access drops it, ATN or leaving TACS drops only the out-transfer part
  assign transfer_request_pin_o = (in_live_r && mask2_r[`M2_IN_XFER])
                                || (out_live_r && mask2_r[`M2_OUT_XFER]);

  assign srq_o             = poll_r[`POLL_RSV];
  assign poll_byte_o       = poll_r;
  assign ah_holdoff_o      = hold_r;
  assign device_fire_pin_o = fire_r;
  assign sec_accept_o      = accept_r;
  assign sec_reject_o      = reject_r;
  assign data_out_o        = dout_r;
  assign data_out_load_o   = dout_load_r;
  assign d_o               = dout_q_r;

  always_comb begin
    mask1_nxt       = mask1_r;
    mask2_nxt       = mask2_r;
    poll_nxt        = poll_r;
    mode_nxt        = mode_r;
    aux_a_nxt       = aux_a_r;
    aux_b_nxt       = aux_b_r;
    term_nxt        = term_r;
    din_nxt         = din_r;
    dout_nxt        = dout_r;
    dout_load_nxt   = 1'b0;
    after_undef_nxt = after_undef_r;
    poll_seen_nxt   = poll_seen_r;
    in_live_nxt     = in_live_r;
    out_live_nxt    = out_live_r;
    hold_nxt        = hold_r;
    d_nxt           = dout_q_r;

    if (byte_accept_i && st_i.lacs) begin
      din_nxt = dio_i;
    end
    if (undef_cmd_i && cmd_ok) begin
      after_undef_nxt = 1'b1;
    end else if (primary_cmd_i) begin
      after_undef_nxt = 1'b0;
    end

    // Service request is cleared on leaving SPAS once the byte was read there
    if (st_i.spas && poll_read_i && poll_r[`POLL_RSV]) begin
      poll_seen_nxt = 1'b1;
    end
    if (poll_exit && poll_seen_r) begin
      poll_nxt[`POLL_RSV] = 1'b0;
      poll_seen_nxt       = 1'b0;
    end else if (poll_exit) begin
      poll_seen_nxt = 1'b0;
    end

    if (rd_start && (sel == `RS_DATA)) begin
      in_live_nxt = 1'b0;
    end
    if ((wr_start && (sel == `RS_DATA)) || atn_i || !st_i.tacs) begin
      out_live_nxt = 1'b0;
    end
    if (rd_start && (sel == `RS_PASS)) begin
      hold_nxt = 1'b0;
    end
    if (ev1[`S1_BYTE_IN]) begin
      in_live_nxt = 1'b1;
    end
    if (ev1[`S1_BYTE_OUT]) begin
      out_live_nxt = 1'b1;
    end
    if (ev1[`S1_UNDEF_CMD] || ev1[`S1_SEC_CHECK]) begin
      hold_nxt = 1'b1;
    end

    if (wr_start) begin
      case (sel)
        `RS_DATA: begin
          dout_nxt      = d_i;
          dout_load_nxt = 1'b1;
        end
        `RS_STAT1: mask1_nxt = d_i;
        `RS_STAT2: mask2_nxt = d_i;
        `RS_POLL:  poll_nxt  = d_i;
        `RS_ADDR:  mode_nxt  = addr_mode_t'(d_i[1:0]);
        `RS_PASS: begin
          if (d_i[7:5] == `AUX_PFX_A) begin
            aux_a_nxt = d_i[4:0];
          end else if (d_i[7:5] == `AUX_PFX_B) begin
            aux_b_nxt = d_i[4:0];
          end
        end
        `RS_TERM:  term_nxt  = d_i;
        default:   dout_load_nxt = 1'b0;
      endcase
    end

    // Read value is frozen at the start so the clear cannot disturb it
    if (rd_start) begin
      case (sel)
        `RS_DATA:  d_nxt = din_r;
        `RS_STAT1: d_nxt = stat1;
        `RS_STAT2: d_nxt = stat2;
        `RS_POLL:  d_nxt = poll_r;
        `RS_ADDR:  d_nxt = {int_o, 5'h00, st_i.tads, st_i.lads};
        `RS_PASS:  d_nxt = dio_i;
        `RS_TERM:  d_nxt = term_r;
        default:   d_nxt = `RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mask1_r       <= `RST_BYTE;
      mask2_r       <= `RST_BYTE;
      poll_r        <= `RST_BYTE;
      mode_r        <= addr_mode_t'(`RST_MODE);
      aux_a_r       <= 5'h00;
      aux_b_r       <= 5'h00;
      term_r        <= `RST_BYTE;
      din_r         <= `RST_BYTE;
      dout_r        <= `RST_BYTE;
      dout_load_r   <= 1'b0;
      after_undef_r <= 1'b0;
      poll_seen_r   <= 1'b0;
      in_live_r     <= 1'b0;
      out_live_r    <= 1'b0;
      hold_r        <= 1'b0;
      fire_r        <= 1'b0;
      accept_r      <= 1'b0;
      reject_r      <= 1'b0;
      rd_prev_r     <= 1'b0;
      wr_prev_r     <= 1'b0;
      out_prev_r    <= 1'b0;
      err_prev_r    <= 1'b0;
      dcas_prev_r   <= 1'b0;
      spas_prev_r   <= 1'b0;
      chg_prev_r    <= 7'h00;
      dout_q_r      <= `RST_BYTE;
    end else begin
      mask1_r       <= mask1_nxt;
      mask2_r       <= mask2_nxt;
      poll_r        <= poll_nxt;
      mode_r        <= mode_nxt;
      aux_a_r       <= aux_a_nxt;
      aux_b_r       <= aux_b_nxt;
      term_r        <= term_nxt;
      din_r         <= din_nxt;
      dout_r        <= dout_nxt;
      dout_load_r   <= dout_load_nxt;
      after_undef_r <= after_undef_nxt;
      poll_seen_r   <= poll_seen_nxt;
      in_live_r     <= in_live_nxt;
      out_live_r    <= out_live_nxt;
      hold_r        <= hold_nxt;
      fire_r        <= ev1[`S1_TRIGGER];
      accept_r      <= wr_start && (sel == `RS_PASS) && (d_i == `AUX_SEC_ACCEPT);
      reject_r      <= wr_start && (sel == `RS_PASS) && (d_i == `AUX_SEC_REJECT);
      rd_prev_r     <= rd_act;
      wr_prev_r     <= wr_act;
      out_prev_r    <= out_ready_i;
      err_prev_r    <= err_cond;
      dcas_prev_r   <= dcas_i;
      spas_prev_r   <= st_i.spas;
      chg_prev_r    <= chg_now;
      dout_q_r      <= d_nxt;
    end
  end

endmodule

// ### gpib_talker_listener_events_tb.sv
// Self-checking bench for the talker/listener event block
`include "gpib_evt_defs.svh"
module gpib_talker_listener_events_tb
  import gpib_evt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] TRG = 7'h40, ADR = 7'h20, UND = 7'h10, PRI = 7'h08, SEC = 7'h04;
  logic         clk_sys_i = 1'b0;
  logic         rst_i = 1'b1;
  host_bus_t    host = 6'h38;
  logic [7:0]   d_i = 8'h00;
  logic [7:0]   d_o, data_out_o, poll_byte_o, dio, dv;
  logic         int_o, req, srq_o, ah_holdoff_o, sec_accept_o, sec_reject_o, eoi, acc, fire, oe, ld;
  iface_state_t st, sv;
  logic [5:0]   lv;
  logic [6:0]   pu;
  logic [7:0]   exp_q[$];
  logic [7:0]   chg[3] = '{8'h01, 8'h22, 8'h34};
  logic         go_r = 1'b0, rd_l = 1'b0;
  int           miscompares = 0, compares = 0, cycles = 0, ldn = 0;
  logic [31:0]  rnd = 32'h12fe;

  always #4 clk_sys_i = ~clk_sys_i;

  ctrl_model ctrl_model_inst (.clk_sys_i, .st_o(st), .dio_o(dio), .eoi_o(eoi), .acc_o(acc),
    .lv_o(lv), .pu_o(pu));

  gpib_talker_listener_events gpib_talker_listener_events_inst (
    .clk_sys_i, .rst_i, .host_i(host), .d_i, .d_o, .d_oe_o(oe), .st_i(st), .dio_i(dio),
    .eoi_i(eoi), .atn_i(lv[5]), .byte_accept_i(acc), .out_ready_i(lv[4]), .nba_i(lv[3]),
    .dac_i(lv[2]), .rfd_i(lv[1]), .dcas_i(lv[0]), .trigger_cmd_i(pu[6]),
    .addressed_cmd_i(pu[5]), .undef_cmd_i(pu[4]), .primary_cmd_i(pu[3]),
    .sec_cmd_i(pu[2]), .sec_match_i(pu[1]), .poll_read_i(pu[0]), .int_o,
    .transfer_request_pin_o(req), .device_fire_pin_o(fire), .srq_o, .poll_byte_o,
    .ah_holdoff_o, .sec_accept_o, .sec_reject_o, .data_out_o, .data_out_load_o(ld));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Strobes held through the answer edge, then one idle cycle
  task automatic access(input logic w, input logic [2:0] r, input logic [7:0] d);
    @(posedge clk_sys_i);
    host <= {1'b0, w, !w, r};
    d_i <= d;
    repeat (2) @(posedge clk_sys_i);
    host <= {3'b111, r};
    @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [2:0] r, input logic [7:0] exp);
    exp_q.push_back(exp);
    access(1'b0, r, 8'h00);
  endtask

  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    access(1'b1, r, d);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // Read data is checked one edge after the access is taken
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
    rd_l <= !host.cs_n && !host.rd_n;
    go_r <= !host.cs_n && !host.rd_n && !rd_l;
    if (ld) ldn++;
    if (go_r) begin
      chk1(oe, 1'b1);
      #1;
      chk8(d_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    $display("reset test done");
    sv = '0;
    sv.lads = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.pulse(TRG);
    #1 chk1(fire, 1'b1);
    rd(`RS_STAT1, 8'h20);
    rd(`RS_STAT1, 8'h00);
    sv.lads = 1'b0;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.pulse(TRG | ADR);
    #1 chk1(fire, 1'b0);
    rd(`RS_STAT1, 8'h00);
    sv.tacs = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.set_lv(6'h0e);
    rd(`RS_STAT1, 8'h04);
    sv = '0;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.set_lv(6'h01);
    rd(`RS_STAT1, 8'h08);
    ctrl_model_inst.set_lv(6'h00);
    $display("event test done");
    sv.lacs = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.take(8'h55, 1'b1);
    rd(`RS_STAT1, 8'h11);
    wr(`RS_TERM, 8'h0a);
    wr(`RS_PASS, 8'h84);
    ctrl_model_inst.take(8'h0a, 1'b0);
    rd(`RS_STAT1, 8'h11);
    ctrl_model_inst.take(8'h0b, 1'b0);
    rd(`RS_STAT1, 8'h01);
    $display("end test done");
    wr(`RS_STAT1, 8'h20);
    sv.lads = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.pulse(TRG);
    rd(`RS_ADDR, 8'h81);
    ctrl_model_inst.set_lv(6'h01);
    ctrl_model_inst.pulse(TRG);
    rd(`RS_STAT2, 8'h80);
    rd(`RS_STAT1, 8'h20);
    rd(`RS_STAT1, 8'h08);
    ctrl_model_inst.set_lv(6'h00);
    $display("hold test done");
    wr(`RS_STAT1, 8'h01);
    wr(`RS_STAT2, 8'h20);
    rnd = lfsr(rnd);
    dv = rnd[7:0] | 8'h80;
    ctrl_model_inst.take(dv, 1'b0);
    settle();
    chk1(int_o, 1'b1);
    chk1(req, 1'b0);
    rd(`RS_DATA, dv);
    settle();
    chk1(int_o, 1'b0);
    sv = '0;
    sv.tacs = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.set_lv(6'h10);
    settle();
    chk1(req, 1'b1);
    chk1(int_o, 1'b0);
    rd(`RS_STAT1, 8'h02);
    chk1(req, 1'b1);
    rnd = lfsr(rnd);
    wr(`RS_DATA, rnd[7:0]);
    settle();
    chk1(req, 1'b0);
    chk8(data_out_o, rnd[7:0]);
    chk8(8'(ldn), 8'h01);
    ctrl_model_inst.set_lv(6'h00);
    ctrl_model_inst.set_lv(6'h10);
    settle();
    chk1(req, 1'b1);
    ctrl_model_inst.set_lv(6'h30);
    settle();
    chk1(req, 1'b0);
    sv = '0;
    sv.lacs = 1'b1;
    ctrl_model_inst.set_st(sv);
    ctrl_model_inst.set_lv(6'h00);
    wr(`RS_STAT2, 8'h10);
    ctrl_model_inst.take(8'h33, 1'b0);
    settle();
    chk1(req, 1'b1);
    rd(`RS_DATA, 8'h33);
    settle();
    chk1(req, 1'b0);
    $display("request test done");
    wr(`RS_POLL, 8'h41);
    settle();
    chk1(srq_o, 1'b1);
    chk8(poll_byte_o, 8'h41);
    rd(`RS_POLL, 8'h41);
    ctrl_model_inst.poll();
    rd(`RS_POLL, 8'h01);
    rd(`RS_STAT2, 8'h08);
    ctrl_model_inst.poll();
    rd(`RS_STAT2, 8'h00);
    chk1(srq_o, 1'b0);
    $display("poll test done");
    sv = '0;
    for (int i = 0; i < 3; i++) begin
      sv.lids = 1'b1;
      sv.rems = i > 0;
      sv.rwls = i > 1;
      ctrl_model_inst.set_st(sv);
      rd(`RS_STAT2, chg[i]);
    end
    $display("state change test done");
    wr(`RS_PASS, 8'ha1);
    ctrl_model_inst.pulse(UND);
    settle();
    chk1(ah_holdoff_o, 1'b1);
    rd(`RS_STAT1, 8'h80);
    ctrl_model_inst.pulse(SEC);
    rd(`RS_STAT1, 8'h80);
    ctrl_model_inst.pulse(PRI);
    ctrl_model_inst.pulse(SEC);
    rd(`RS_STAT1, 8'h00);
    rnd = lfsr(rnd);
    ctrl_model_inst.drive(rnd[7:0]);
    rd(`RS_PASS, rnd[7:0]);
    chk1(ah_holdoff_o, 1'b0);
    sv.tpas = 1'b1;
    ctrl_model_inst.set_st(sv);
    for (int m = 1; m < 4; m++) begin
      wr(`RS_ADDR, 8'(m));
      ctrl_model_inst.pulse(SEC);
      rd(`RS_STAT1, m == 3 ? 8'h40 : 8'h00);
    end
    ctrl_model_inst.pulse(SEC | 7'h02);
    rd(`RS_STAT1, 8'h00);
    wr(`RS_PASS, `AUX_SEC_REJECT);
    wr(`RS_PASS, `AUX_SEC_ACCEPT);
    $display("pass-through test done");
    settle();
    summarize();
  end
endmodule

// ### status_hold.sv
// Sticky status register with a temporary store for events arriving while blocked
`include "gpib_evt_defs.svh"
module status_hold #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] ev_i,
  input  wire logic [W-1:0] mask_i,
  input  wire logic         rd_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] stat_o
);

  logic [W-1:0] stat_r;
  logic [W-1:0] stat_nxt;
  logic [W-1:0] tmp_r;
  logic [W-1:0] tmp_nxt;
  logic         blocked;

  assign blocked = |(stat_r & mask_i);
  assign stat_o  = stat_r;

  always_comb begin
    stat_nxt = stat_r;
    tmp_nxt  = tmp_r;
    if (rd_i) begin
      // Held events move in only where the bit was read as zero
      stat_nxt = tmp_r & ~stat_r;
      tmp_nxt  = '0;
    end else if (!blocked) begin
      stat_nxt = stat_r | tmp_r;
      tmp_nxt  = '0;
    end
    stat_nxt = stat_nxt & ~clr_i;
    tmp_nxt  = tmp_nxt & ~clr_i;
    // A new event wins over any clear in the same cycle
    if (blocked && !rd_i) begin
      tmp_nxt = tmp_nxt | ev_i;
    end else begin
      stat_nxt = stat_nxt | ev_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_r <= '0;
      tmp_r  <= '0;
    end else begin
      stat_r <= stat_nxt;
      tmp_r  <= tmp_nxt;
    end
  end

endmodule
